// ### ofu_pkg.sv
// Shared constants and carrier types for the operand format unit
package ofu_pkg;

	localparam int XLEN          = 64;
	localparam int WLEN          = 32;
	localparam int SGL_SIGN_BIT  = 31;
	localparam int SGL_EXP_HI    = 30;
	localparam int SGL_EXP_LO    = 23;
	localparam int SGL_FRAC_HI   = 22;
	localparam int SGL_EXP_W     = 8;
	localparam int SGL_FRAC_W    = 23;
	localparam int SGL_BIAS      = 127;
	localparam int DBL_SIGN_BIT  = 63;
	localparam int DBL_EXP_HI    = 62;
	localparam int DBL_EXP_LO    = 52;
	localparam int DBL_FRAC_HI   = 51;
	localparam int DBL_EXP_W     = 11;
	localparam int DBL_FRAC_W    = 52;
	localparam int DBL_BIAS      = 1023;
	localparam int UNB_EXP_W     = 12;
	localparam logic [63:0] ZERO64 = 64'h0000000000000000;

	// Access size code
	typedef enum logic [2:0] {
		OFU_SZ_8   = 3'h0,
		OFU_SZ_16  = 3'h1,
		OFU_SZ_32  = 3'h2,
		OFU_SZ_64  = 3'h3,
		OFU_SZ_128 = 3'h4
	} ofu_size_t;

	// Datapath operation select
	typedef enum logic [3:0] {
		OFU_OP_NONE    = 4'h0,
		OFU_OP_LOAD    = 4'h1,
		OFU_OP_STORE   = 4'h2,
		OFU_OP_ADD     = 4'h3,
		OFU_OP_SUB     = 4'h4,
		OFU_OP_FP_SGL  = 4'h5,
		OFU_OP_FP_DBL  = 4'h6,
		OFU_OP_PIXEL   = 4'h7,
		OFU_OP_CTRL_LD = 4'h8,
		OFU_OP_CTRL_ST = 4'h9
	} ofu_op_t;

	typedef enum logic [1:0] {
		OFU_PIX_8  = 2'h0,
		OFU_PIX_16 = 2'h1,
		OFU_PIX_32 = 2'h2
	} ofu_pix_t;

	typedef enum logic [1:0] {
		OFU_CL_NORMAL = 2'h0,
		OFU_CL_ZERO   = 2'h1,
		OFU_CL_TRAP   = 2'h2
	} ofu_class_t;

	// One request from the issue stage
	typedef struct packed {
		logic       valid;
		ofu_op_t    op;
		ofu_size_t  size;
		logic       is_signed;
		ofu_pix_t   pix;
		logic [4:0] freg;
		logic [127:0] a;
		logic [63:0]  b;
	} ofu_req_t;

	// Decoded real operand
	typedef struct packed {
		ofu_class_t cls;
		logic       sign;
		logic [UNB_EXP_W-1:0] exp_unb;
		logic [52:0] mant;
	} ofu_real_t;

	// One answer to the register files and trap logic
	typedef struct packed {
		logic        valid;
		logic        wr_en;
		logic        ctrl_sel;
		logic [127:0] data;
		logic [15:0] byte_en;
		logic [4:0]  freg_even;
		logic [4:0]  freg_odd;
		logic        carry;
		logic        ovf;
		logic        src_exc;
		ofu_real_t   real_a;
		ofu_real_t   real_b;
	} ofu_rsp_t;

endpackage

// ### ofu_real_decode.sv
// Combinational classifier for one single or double real operand
`timescale 1ns/100ps
module ofu_real_decode (
	input  wire logic        is_dbl_i,
	input  wire logic [63:0] value_i,
	output ofu_pkg::ofu_real_t real_o
);
	logic                              sign;
	logic [ofu_pkg::DBL_EXP_W-1:0]    exp;
	logic [ofu_pkg::DBL_FRAC_W-1:0]   frac;
	logic [ofu_pkg::DBL_EXP_W-1:0]    exp_max;
	logic [ofu_pkg::UNB_EXP_W-1:0]    bias;

	always_comb begin
		if (is_dbl_i) begin
			sign    = value_i[ofu_pkg::DBL_SIGN_BIT];             // [RULE_10]
			exp     = value_i[ofu_pkg::DBL_EXP_HI:ofu_pkg::DBL_EXP_LO];
			frac    = value_i[ofu_pkg::DBL_FRAC_HI:0];
			exp_max = '1;
			bias    = ofu_pkg::UNB_EXP_W'(ofu_pkg::DBL_BIAS);
		end else begin
			sign    = value_i[ofu_pkg::SGL_SIGN_BIT];             // [RULE_08]
			exp     = {3'h0, value_i[ofu_pkg::SGL_EXP_HI:ofu_pkg::SGL_EXP_LO]};
			// Left-align the short fraction so mantissa width is shared
			frac    = {value_i[ofu_pkg::SGL_FRAC_HI:0], 29'h00000000};
			exp_max = 11'h0FF;
			bias    = ofu_pkg::UNB_EXP_W'(ofu_pkg::SGL_BIAS);
		end
		real_o.sign = sign;                                       // [RULE_12]
		real_o.mant = {1'b1, frac};
		real_o.exp_unb = {1'b0, exp} - bias;                      // [RULE_09] [RULE_11]
		if (exp == exp_max || (exp == '0 && frac != '0)) begin
			real_o.cls  = ofu_pkg::OFU_CL_TRAP;                   // [RULE_13]
		end else if (exp == '0) begin
			real_o.cls  = ofu_pkg::OFU_CL_ZERO;                   // [RULE_12]
			real_o.mant = '0;
			real_o.exp_unb = '0;
		end else begin
			real_o.cls  = ofu_pkg::OFU_CL_NORMAL;
		end
	end
endmodule

// ### ofu_addsub.sv
// 64-bit adder and subtractor with signed and unsigned flags
`timescale 1ns/100ps
module ofu_addsub #(
	parameter int WIDTH = 64
) (
	input  wire logic [WIDTH-1:0] a_i,
	input  wire logic [WIDTH-1:0] b_i,
	input  wire logic             sub_i,
	input  wire logic             is_signed_i,
	output logic      [WIDTH-1:0] sum_o,
	output logic                  carry_o,
	output logic                  ovf_o
);
	logic [WIDTH:0]   wide;
	logic [WIDTH-1:0] b_eff;

	always_comb begin
		b_eff   = sub_i ? ~b_i : b_i;
		wide    = {1'b0, a_i} + {1'b0, b_eff} + {{WIDTH{1'b0}}, sub_i};   // [RULE_07]
		sum_o   = wide[WIDTH-1:0];
		// Unsigned: carry out on add, borrow on subtract
		carry_o = sub_i ? ~wide[WIDTH] : wide[WIDTH];                      // [RULE_06]
		ovf_o   = is_signed_i
			? ((a_i[WIDTH-1] == b_eff[WIDTH-1]) && (sum_o[WIDTH-1] != a_i[WIDTH-1]))
			: carry_o;                                                     // [RULE_03]
	end
endmodule

// ### ofu_top.sv
// Operand format unit: load/store sizing, real classification, pixel groups
`timescale 1ns/100ps

// Functional notes
// (RULE_01) Bit zero is least significant everywhere
// (RULE_02) Accesses of 8 to 128 bits
// (RULE_03) Integers are 32-bit two's complement
// (RULE_04) Narrow loads sign-extend to 32 bits
// (RULE_05) Narrow stores use only low bits
// (RULE_06) Ordinals are 32-bit unsigned
// (RULE_07) 64-bit add and subtract, both interpretations
// (RULE_08) Single: sign, 8-bit exponent, 23-bit fraction
// (RULE_09) Single normal value uses bias 127
// (RULE_10) Double: sign, 11-bit exponent, 52-bit fraction
// (RULE_11) Double normal value uses bias 1023
// (RULE_12) Zero exponent and fraction: signed zero
// (RULE_13) Special encodings raise source exception trap
// (RULE_14) Only normals and zeros are ever produced
// (RULE_15) Double occupies even/odd register pair
// (RULE_16) Pixels 8/16/32 bits, 64-bit groups
// (RULE_17) Control registers only via control instructions
// (RULE_18) Source check flags trap, suppresses write
module ofu_top (
	input  wire logic              clock_i,
	input  wire logic              resetn_i,
	input  wire ofu_pkg::ofu_req_t req_i,
	output ofu_pkg::ofu_rsp_t      rsp_o
);
	typedef struct packed {
		ofu_pkg::ofu_rsp_t rsp;
	} ofu_state_t;

	ofu_state_t state;
	ofu_state_t next_state;

	ofu_pkg::ofu_real_t real_a;
	ofu_pkg::ofu_real_t real_b;
	logic [63:0]        sum;
	logic               carry;
	logic               ovf;
	logic               is_dbl;

	// Sign-extends a narrow loaded item to a 32-bit register value
	function automatic logic [31:0] ofu_load_ext(input logic [31:0] v,
		input ofu_pkg::ofu_size_t sz, input logic sgn);
		logic [31:0] r;
		r = v;
		case (sz)
			ofu_pkg::OFU_SZ_8:  r = {{24{sgn & v[7]}}, v[7:0]};     // [RULE_04]
			ofu_pkg::OFU_SZ_16: r = {{16{sgn & v[15]}}, v[15:0]};   // [RULE_04]
			default:            r = v;
		endcase
		return r;
	endfunction

	// Byte enables for an access size, lanes counted from bit zero
	function automatic logic [15:0] ofu_lanes(input ofu_pkg::ofu_size_t sz);
		logic [15:0] r;
		case (sz)
			ofu_pkg::OFU_SZ_8:   r = 16'h0001;
			ofu_pkg::OFU_SZ_16:  r = 16'h0003;
			ofu_pkg::OFU_SZ_32:  r = 16'h000F;
			ofu_pkg::OFU_SZ_64:  r = 16'h00FF;
			ofu_pkg::OFU_SZ_128: r = 16'hFFFF;                       // [RULE_02]
			default:             r = 16'h0000;
		endcase
		return r;
	endfunction

	// Widens byte enables into a bit mask, byte n covering bits 8n+7 down to 8n
	function automatic logic [127:0] ofu_lane_mask(input logic [15:0] be);
		logic [127:0] m;
		m = '0;
		for (int i = 0; i < 16; i++) begin
			m[8*i +: 8] = {8{be[i]}};
		end
		return m;
	endfunction

	// Rebuilds a normal or zero real from decoded fields
	function automatic logic [63:0] ofu_pack(input ofu_pkg::ofu_real_t rv,
		input logic dbl);
		logic [63:0] r;
		logic [10:0] e;
		r = ofu_pkg::ZERO64;
		if (dbl) begin
			e = 11'(rv.exp_unb + 12'(ofu_pkg::DBL_BIAS));
		end else begin
			e = 11'(rv.exp_unb + 12'(ofu_pkg::SGL_BIAS));
		end
		// Zero keeps its sign; a trapped special still passes through to data, with its write blocked by wr_en
		if (rv.cls == ofu_pkg::OFU_CL_ZERO) begin
			e = 11'h000;                                             // [RULE_14]
		end
		if (dbl) begin
			r = {rv.sign, e, (rv.cls == ofu_pkg::OFU_CL_ZERO) ? 52'h0 : rv.mant[51:0]};
		end else begin
			r = {32'h00000000, rv.sign, e[7:0],
				(rv.cls == ofu_pkg::OFU_CL_ZERO) ? 23'h000000 : rv.mant[51:29]};
		end
		return r;
	endfunction

	assign is_dbl = (req_i.op == ofu_pkg::OFU_OP_FP_DBL);

	ofu_real_decode u_dec_a (
		.is_dbl_i (is_dbl),
		.value_i  (req_i.a[63:0]),
		.real_o   (real_a)
	);

	ofu_real_decode u_dec_b (
		.is_dbl_i (is_dbl),
		.value_i  (req_i.b),
		.real_o   (real_b)
	);

	ofu_addsub #(
		.WIDTH (ofu_pkg::XLEN)
	) u_addsub (
		.a_i         (req_i.a[63:0]),
		.b_i         (req_i.b),
		.sub_i       (req_i.op == ofu_pkg::OFU_OP_SUB),
		.is_signed_i (req_i.is_signed),
		.sum_o       (sum),
		.carry_o     (carry),
		.ovf_o       (ovf)
	);

	always_comb begin
		next_state             = '0;
		next_state.rsp.valid   = req_i.valid;
		next_state.rsp.real_a  = real_a;
		next_state.rsp.real_b  = real_b;
		next_state.rsp.freg_even = {req_i.freg[4:1], 1'b0};          // [RULE_15]
		next_state.rsp.freg_odd  = {req_i.freg[4:1], 1'b1};          // [RULE_15]
		if (req_i.valid) begin
			case (req_i.op)
				ofu_pkg::OFU_OP_LOAD: begin
					next_state.rsp.wr_en   = 1'b1;
					next_state.rsp.byte_en = ofu_lanes(req_i.size);
					if (req_i.size == ofu_pkg::OFU_SZ_8 || req_i.size == ofu_pkg::OFU_SZ_16) begin
						// Narrow loads always sign-extend; is_signed steers only add and subtract
						next_state.rsp.data = {96'h0,
							ofu_load_ext(req_i.a[31:0], req_i.size, 1'b1)};  // [RULE_04]
						next_state.rsp.byte_en = 16'h000F;
					end else begin
						next_state.rsp.data = req_i.a
							& ofu_lane_mask(ofu_lanes(req_i.size));            // [RULE_01]
					end
				end
				ofu_pkg::OFU_OP_STORE: begin
					next_state.rsp.wr_en   = 1'b1;
					next_state.rsp.byte_en = ofu_lanes(req_i.size);          // [RULE_05]
					case (req_i.size)
						ofu_pkg::OFU_SZ_8:  next_state.rsp.data = {120'h0, req_i.a[7:0]};
						ofu_pkg::OFU_SZ_16: next_state.rsp.data = {112'h0, req_i.a[15:0]};
						ofu_pkg::OFU_SZ_32: next_state.rsp.data = {96'h0, req_i.a[31:0]};
						ofu_pkg::OFU_SZ_64: next_state.rsp.data = {64'h0, req_i.a[63:0]};
						default:            next_state.rsp.data = req_i.a;
					endcase
				end
				ofu_pkg::OFU_OP_ADD, ofu_pkg::OFU_OP_SUB: begin
					next_state.rsp.wr_en = 1'b1;
					next_state.rsp.data  = {64'h0, sum};                     // [RULE_07]
					next_state.rsp.carry = carry;
					next_state.rsp.ovf   = ovf;
				end
				ofu_pkg::OFU_OP_FP_SGL, ofu_pkg::OFU_OP_FP_DBL: begin
					// Any faulting source blocks the write; trap logic emulates it
					next_state.rsp.src_exc = (real_a.cls == ofu_pkg::OFU_CL_TRAP) ||
						(real_b.cls == ofu_pkg::OFU_CL_TRAP);                 // [RULE_13] [RULE_18]
					next_state.rsp.wr_en = ~next_state.rsp.src_exc;          // [RULE_18]
					next_state.rsp.data  = {64'h0, ofu_pack(real_a, is_dbl)}; // [RULE_14]
					next_state.rsp.byte_en = is_dbl ? 16'h00FF : 16'h000F;
				end
				ofu_pkg::OFU_OP_PIXEL: begin
					// Pixel size code 3 blocks the write, other codes change nothing; the group is always 64 bits
					next_state.rsp.wr_en   = (req_i.pix != 2'h3);            // [RULE_16]
					next_state.rsp.data    = {64'h0, req_i.a[63:0]};         // [RULE_16]
					next_state.rsp.byte_en = 16'h00FF;
				end
				ofu_pkg::OFU_OP_CTRL_LD, ofu_pkg::OFU_OP_CTRL_ST: begin
					next_state.rsp.wr_en    = 1'b1;
					next_state.rsp.ctrl_sel = 1'b1;                          // [RULE_17]
					next_state.rsp.data     = {96'h0, req_i.a[31:0]};
					next_state.rsp.byte_en  = 16'h000F;
				end
				default: begin
					next_state.rsp.wr_en = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign rsp_o = state.rsp;
endmodule

// ### ofu_checker.sv
// Port checker for the operand format unit
`timescale 1ns/100ps
module ofu_checker (
	input wire logic              clock_i,
	input wire logic              resetn_i,
	input wire ofu_pkg::ofu_req_t req_i,
	input wire ofu_pkg::ofu_rsp_t rsp_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!resetn_i);
	wire             v  = req_i.valid;
	wire [7:0]       se = req_i.a[30:23];
	wire [10:0]      de = req_i.a[62:52];
	wire             sg = v && req_i.op == ofu_pkg::OFU_OP_FP_SGL;
	wire             dd = v && req_i.op == ofu_pkg::OFU_OP_FP_DBL;
	wire             ld = v && req_i.op == ofu_pkg::OFU_OP_LOAD;
	property p_ld8;
		ld && req_i.size == ofu_pkg::OFU_SZ_8 |=>
			rsp_o.data[31:0] == {{24{$past(req_i.a[7])}}, $past(req_i.a[7:0])};
	endproperty
	a_ld8: assert property (p_ld8) else $error("byte load not sign extended");
	property p_ld16;
		ld && req_i.size == ofu_pkg::OFU_SZ_16 |=>
			rsp_o.data[31:0] == {{16{$past(req_i.a[15])}}, $past(req_i.a[15:0])};
	endproperty
	a_ld16: assert property (p_ld16) else $error("half load not sign extended");
	property p_st8;
		v && req_i.op == ofu_pkg::OFU_OP_STORE && req_i.size == ofu_pkg::OFU_SZ_8 |=>
			rsp_o.byte_en == 16'h0001 && rsp_o.data[7:0] == $past(req_i.a[7:0]);
	endproperty
	a_st8: assert property (p_st8) else $error("byte store lanes wrong");
	property p_strap;
		sg && (se == 8'hFF || (se == 8'h00 && req_i.a[22:0] != 23'h0)) |=>
			rsp_o.src_exc && !rsp_o.wr_en;
	endproperty
	a_strap: assert property (p_strap) else $error("single special not trapped");
	property p_dtrap;
		dd && (de == 11'h7FF || (de == 11'h000 && req_i.a[51:0] != 52'h0)) |=>
			rsp_o.src_exc && !rsp_o.wr_en;
	endproperty
	a_dtrap: assert property (p_dtrap) else $error("double special not trapped");
	property p_pair;
		dd |=> rsp_o.freg_even == {$past(req_i.freg[4:1]), 1'b0}
			&& rsp_o.freg_odd == {$past(req_i.freg[4:1]), 1'b1};
	endproperty
	a_pair: assert property (p_pair) else $error("register pair wrong");
	property p_add;
		v && req_i.op == ofu_pkg::OFU_OP_ADD |=>
			rsp_o.data[63:0] == $past(req_i.a[63:0]) + $past(req_i.b);
	endproperty
	a_add: assert property (p_add) else $error("sum wrong");
	property p_sub;
		v && req_i.op == ofu_pkg::OFU_OP_SUB |=>
			rsp_o.data[63:0] == $past(req_i.a[63:0]) - $past(req_i.b);
	endproperty
	a_sub: assert property (p_sub) else $error("difference wrong");
	property p_szero;
		sg && req_i.a[30:0] == 31'h0 |=> rsp_o.real_a.cls == ofu_pkg::OFU_CL_ZERO
			&& rsp_o.real_a.sign == $past(req_i.a[31]);
	endproperty
	a_szero: assert property (p_szero) else $error("signed zero lost");
	property p_sexp;
		sg && se != 8'h00 && se != 8'hFF |=> rsp_o.real_a.exp_unb == 12'($past(se)) - 12'h07F;
	endproperty
	a_sexp: assert property (p_sexp) else $error("single bias wrong");
	property p_ctrl;
		v |=> rsp_o.ctrl_sel == ($past(req_i.op) inside
			{ofu_pkg::OFU_OP_CTRL_LD, ofu_pkg::OFU_OP_CTRL_ST});
	endproperty
	a_ctrl: assert property (p_ctrl) else $error("control select wrong");
	c_trap: cover property (sg ##1 rsp_o.src_exc);
	c_pair: cover property (dd ##1 rsp_o.wr_en);
	c_load: cover property (ld ##1 ld);
endmodule

// ### ofu_rf_model.sv
// Floating register file that takes the unit's writes
`timescale 1ns/100ps
module ofu_rf_model (
	input  wire logic              clock_i,
	input  wire ofu_pkg::ofu_rsp_t rsp_i,
	input  wire logic [4:0]        rd_idx_i,
	output logic      [31:0]       rd_o
);
	logic [31:0] regs [32];
	// Low word to the even register, high word to the odd one
	always @(posedge clock_i) begin
		if (rsp_i.valid && rsp_i.wr_en) begin
			regs[rsp_i.freg_even] <= rsp_i.data[31:0];
			regs[rsp_i.freg_odd] <= rsp_i.data[63:32];
		end
	end
	assign rd_o = regs[rd_idx_i];
endmodule

// ### tb_top.sv
// Directed testbench for the operand format unit
`timescale 1ns/100ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_count++; \
	$display("ERROR %0t got %0h exp %0h", $time, (a), (e)); end end
module tb_top;
	logic              clock_i = 1'b0;
	logic              resetn_i = 1'b0;
	ofu_pkg::ofu_req_t req = '0;
	ofu_pkg::ofu_rsp_t rsp;
	logic [4:0]        idx = 5'h00;
	logic [31:0]       rd;
	int                err_count = 0;
	int                tests_run = 0;
	always #5 clock_i = ~clock_i;
	ofu_top i_ofu_top (.clock_i(clock_i), .resetn_i(resetn_i), .req_i(req), .rsp_o(rsp));
	ofu_rf_model i_ofu_rf_model (.clock_i(clock_i), .rsp_i(rsp), .rd_idx_i(idx), .rd_o(rd));
	// Called at a falling edge; the answer stands at the next one
	task automatic iss(ofu_pkg::ofu_op_t op, logic [127:0] a, logic [63:0] b = '0);
		req.valid = 1'b1;
		req.op = op;
		req.a = a;
		req.b = b;
		@(negedge clock_i);
	endtask
	task automatic t_mem;
		req.size = ofu_pkg::OFU_SZ_8;
		iss(ofu_pkg::OFU_OP_LOAD, 128'h80);
		`CHK(rsp.data[31:0], 32'hFFFFFF80)
		`CHK(rsp.byte_en, 16'h000F)
		iss(ofu_pkg::OFU_OP_STORE, 128'h12345678);
		`CHK(rsp.byte_en, 16'h0001)
		`CHK(rsp.data[7:0], 8'h78)
		req.size = ofu_pkg::OFU_SZ_16;
		iss(ofu_pkg::OFU_OP_LOAD, 128'h8001);
		`CHK(rsp.data[31:0], 32'hFFFF8001)
		iss(ofu_pkg::OFU_OP_STORE, 128'h12345678);
		`CHK(rsp.byte_en, 16'h0003)
		req.size = ofu_pkg::OFU_SZ_128;
		iss(ofu_pkg::OFU_OP_LOAD, {2{64'h0123456789ABCDEF}});
		`CHK(rsp.data, {2{64'h0123456789ABCDEF}})
		$display("Test mem done");
	endtask
	task automatic t_arith;
		req.is_signed = 1'b1;
		iss(ofu_pkg::OFU_OP_ADD, 128'h7FFFFFFFFFFFFFFF, 64'h1);
		`CHK(rsp.data[63:0], 64'h8000000000000000)
		`CHK(rsp.ovf, 1'b1)
		req.is_signed = 1'b0;
		iss(ofu_pkg::OFU_OP_SUB, 128'h1, 64'h2);
		`CHK(rsp.data[63:0], 64'hFFFFFFFFFFFFFFFF)
		`CHK(rsp.carry, 1'b1)
		$display("Test arith done");
	endtask
	task automatic t_real;
		logic [31:0] sv [5] = '{32'h7F800000, 32'h00000001, 32'h7FC00000,
			32'h80000000, 32'h3F800000};
		for (int i = 0; i < 5; i++) begin
			iss(ofu_pkg::OFU_OP_FP_SGL, {96'h0, sv[i]});
			`CHK(rsp.src_exc, (i < 3))
			`CHK(rsp.wr_en, (i >= 3))
		end
		`CHK(rsp.real_a.exp_unb, 12'h000)
		`CHK(rsp.data[31:0], 32'h3F800000)
		req.freg = 5'd5;
		iss(ofu_pkg::OFU_OP_FP_DBL, 128'h7FF0000000000000);
		`CHK(rsp.src_exc, 1'b1)
		iss(ofu_pkg::OFU_OP_FP_DBL, 128'h4000000000000001);
		`CHK(rsp.real_a.exp_unb, 12'h001)
		`CHK(rsp.freg_even, 5'h04)
		`CHK(rsp.real_a.mant, 53'h10000000000001)
		`CHK(rsp.real_b.cls, ofu_pkg::OFU_CL_ZERO)
		req.valid = 1'b0;
		@(negedge clock_i);
		idx = 5'd4;
		#1 `CHK(rd, 32'h00000001)
		idx = 5'd5;
		#1 `CHK(rd, 32'h40000000)
		@(negedge clock_i);
		$display("Test real done");
	endtask
	task automatic t_misc;
		for (int p = 0; p < 4; p++) begin
			req.pix = ofu_pkg::ofu_pix_t'(p);
			iss(ofu_pkg::OFU_OP_PIXEL, {2{64'h00FF00FF00FF00FF}});
			`CHK(rsp.wr_en, (p != 3))
			`CHK(rsp.data, {64'h0, 64'h00FF00FF00FF00FF})
			`CHK(rsp.byte_en, 16'h00FF)
		end
		iss(ofu_pkg::OFU_OP_CTRL_LD, 128'h0);
		`CHK(rsp.ctrl_sel, 1'b1)
		iss(ofu_pkg::OFU_OP_CTRL_ST, 128'h0);
		`CHK(rsp.ctrl_sel, 1'b1)
		iss(ofu_pkg::OFU_OP_ADD, 128'h0);
		`CHK(rsp.ctrl_sel, 1'b0)
		req.valid = 1'b0;
		resetn_i = 1'b0;
		#1 `CHK(rsp, ofu_pkg::ofu_rsp_t'('0))
		@(negedge clock_i);
		resetn_i = 1'b1;
		@(negedge clock_i);
		// Work resumes after a mid-run reset, including back-to-back loads
		req.size = ofu_pkg::OFU_SZ_32;
		iss(ofu_pkg::OFU_OP_LOAD, {2{64'h89ABCDEF01234567}});
		`CHK(rsp.data, {96'h0, 32'h01234567})
		`CHK(rsp.valid, 1'b1)
		req.size = ofu_pkg::OFU_SZ_64;
		iss(ofu_pkg::OFU_OP_LOAD, {2{64'h89ABCDEF01234567}});
		`CHK(rsp.data, {64'h0, 64'h89ABCDEF01234567})
		iss(ofu_pkg::OFU_OP_STORE, {2{64'h89ABCDEF01234567}});
		`CHK(rsp.byte_en, 16'h00FF)
		`CHK(rsp.data, {64'h0, 64'h89ABCDEF01234567})
		req.valid = 1'b0;
		@(negedge clock_i);
		$display("Test misc done");
	endtask
	task automatic report_and_stop;
		$display("Checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(negedge clock_i);
		resetn_i = 1'b1;
		@(negedge clock_i);
		t_mem();
		t_arith();
		t_real();
		t_misc();
		report_and_stop();
	end
	// Whole run needs well under a thousand cycles
	initial begin
		#20000;
		err_count++;
		report_and_stop();
	end
endmodule
bind ofu_top ofu_checker i_ofu_checker (.clock_i(clock_i), .resetn_i(resetn_i),
	.req_i(req_i), .rsp_o(rsp_o));
